// [logic/iso_serial_regs.vh]
// constants for the isolated fast serial link: frame layout, commands, fifo shape
// assumes inclusion by bare name from the link module
`ifndef ISO_SERIAL_REGS_VH
`define ISO_SERIAL_REGS_VH

// ==========================================================
// frame layout
`define ISL_START_LEVEL 1'b0
`define ISL_IDLE_LEVEL 1'b1
`define ISL_TX_LAST_IDX 4'h9
`define ISL_RX_FIRST_DATA_IDX 4'h0
`define ISL_RX_TARGET_CHANNEL_BIT_IDX 4'h8
`define ISL_DATA_BITS 8
`define ISL_CHAN_A 1'b0
`define ISL_CHAN_B 1'b1

// ==========================================================
// mode-select command values
`define ISL_MODE_HOLD 8'h10
`define ISL_MODE_RUN 8'h00

// ==========================================================
// transmit fifo shape
`define ISL_FIFO_WIDTH 9
`define ISL_FIFO_DEPTH 16
`define ISL_FIFO_AW 4

`endif

// [logic/byte_fifo.v]
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable
`timescale 1ns/1ps

module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_i,
  input wire reset_i,
  input wire clk_en_i,
  input wire s_valid_i,
  input wire [WIDTH-1:0] s_data_i,
  output wire s_ready_o,
  output wire m_valid_o,
  output wire [WIDTH-1:0] m_data_o,
  input wire m_ready_i
);

  // ==========================================================
  // storage and pointers
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // extra pointer bit tells full from empty
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign s_ready_o = ~full;
  assign m_valid_o = ~empty;
  assign m_data_o = mem_q[rd_ptr_q[AW-1:0]];
  assign push = s_valid_i && ~full && clk_en_i;
  assign pop = m_ready_i && ~empty && clk_en_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= s_data_i;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule // byte_fifo

// [logic/isolated_fast_serial_link.v]
// four-wire isolated serial port moving bytes between two internal channels
// assumes the far end drives iso_serial_clock well below clock_i/4 (bench: 800 ns)
// Function
// - when any channel uses this mode, the serial pins live on channel B only.
// - mode enabled only by configuration memory selection bits.
// - mode command 10 holds the serial engine in reset; 0 releases it.
// - while held, host bytes are still accepted but not sent out.
// - a transmit frame begins with a low start bit.
// - no transmit frame starts while a receive frame is in progress.
// - outgoing byte follows the start bit, least significant bit first.
// - last outgoing bit names the source: 0 channel A, 1 channel B.
// - after a start bit, clear-to-send drops at the next rising clock edge.
// - eight data bits 0 to 7 are captured least significant first.
// - last incoming bit steers byte; disabled target falls back to the other.
// - with neither channel in this mode, the whole function stays disabled.
// - clear-to-send stays low after data bit 0 until another byte fits.
`timescale 1ns/1ps
`include "iso_serial_regs.vh"

module isolated_fast_serial_link #(
  parameter FIFO_WIDTH = `ISL_FIFO_WIDTH,
  parameter FIFO_DEPTH = `ISL_FIFO_DEPTH,
  parameter FIFO_AW = `ISL_FIFO_AW
) (
  input wire clock_i,
  input wire reset_i,
  input wire clk_en_i,
  input wire cfg_chan_a_fast_i,
  input wire cfg_chan_b_fast_i,
  input wire mode_cmd_valid_i,
  input wire [7:0] mode_cmd_value_i,
  input wire tx_a_valid_i,
  input wire [7:0] tx_a_data_i,
  output wire tx_a_ready_o,
  input wire tx_b_valid_i,
  input wire [7:0] tx_b_data_i,
  output wire tx_b_ready_o,
  output wire [7:0] rx_data_o,
  output wire rx_a_valid_o,
  input wire rx_a_ready_i,
  output wire rx_b_valid_o,
  input wire rx_b_ready_i,
  input wire iso_serial_clock_i,
  input wire iso_serial_in_i,
  output wire iso_serial_out_o,
  output wire iso_clear_to_send_o,
  output wire chan_b_pins_fast_o,
  output wire engine_held_o
);

  // ==========================================================
  // pin synchronisers
  reg sclk_meta_q;
  reg sclk_sync_q;
  reg sclk_prev_q;
  reg sin_meta_q;
  reg sin_sync_q;
  wire sclk_rise;
  wire sclk_fall;

  always @(posedge clock_i) begin
    if (reset_i) begin
      sclk_meta_q <= 1'b0;
      sclk_sync_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      sin_meta_q <= 1'b1;
      sin_sync_q <= 1'b1;
    end else if (clk_en_i) begin
      sclk_meta_q <= iso_serial_clock_i;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
      sin_meta_q <= iso_serial_in_i;
      sin_sync_q <= sin_meta_q;
    end
  end

  // edges of the far end's clock are the only pacing the engine has
  assign sclk_rise = clk_en_i && sclk_sync_q && ~sclk_prev_q;
  assign sclk_fall = clk_en_i && ~sclk_sync_q && sclk_prev_q;

  // ==========================================================
  // configuration and soft reset
  reg cfg_a_q;
  reg cfg_b_q;
  reg hold_q;
  wire fn_en;
  wire running;

  // straps caught while reset is applied, held until the next reset
  always @(posedge clock_i) begin
    if (reset_i) begin
      cfg_a_q <= cfg_chan_a_fast_i;
      cfg_b_q <= cfg_chan_b_fast_i;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      hold_q <= 1'b0;
    end else if (clk_en_i && mode_cmd_valid_i) begin
      if (mode_cmd_value_i == `ISL_MODE_HOLD) begin
        hold_q <= 1'b1;
      end else if (mode_cmd_value_i == `ISL_MODE_RUN) begin
        hold_q <= 1'b0;
      end
    end
  end

  assign fn_en = cfg_a_q | cfg_b_q;
  assign running = fn_en && ~hold_q;
  assign chan_b_pins_fast_o = fn_en;
  assign engine_held_o = hold_q;

  // ==========================================================
  // host side transmit arbiter
  reg prio_b_q;
  wire a_ok;
  wire b_ok;
  wire fifo_s_ready;
  wire push_a;
  wire push_b;
  wire [FIFO_WIDTH-1:0] fifo_s_data;

  // intake stays open in soft reset so the host can queue bytes
  assign a_ok = fn_en && cfg_a_q;
  assign b_ok = fn_en && cfg_b_q;
  assign tx_a_ready_o = fifo_s_ready && a_ok && ~(b_ok && tx_b_valid_i && prio_b_q);
  assign tx_b_ready_o = fifo_s_ready && b_ok && ~(a_ok && tx_a_valid_i && ~prio_b_q);
  assign push_a = tx_a_valid_i && tx_a_ready_o;
  assign push_b = tx_b_valid_i && tx_b_ready_o;
  assign fifo_s_data = push_b ? {`ISL_CHAN_B, tx_b_data_i} : {`ISL_CHAN_A, tx_a_data_i};

  // alternate so neither channel can starve the other
  always @(posedge clock_i) begin
    if (reset_i) begin
      prio_b_q <= 1'b0;
    end else if (clk_en_i && (push_a || push_b)) begin
      prio_b_q <= push_a;
    end
  end

  // ==========================================================
  // transmit fifo
  wire fifo_m_valid;
  wire [FIFO_WIDTH-1:0] fifo_m_data;
  wire tx_pop;

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) tx_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .s_valid_i(push_a || push_b),
    .s_data_i(fifo_s_data),
    .s_ready_o(fifo_s_ready),
    .m_valid_o(fifo_m_valid),
    .m_data_o(fifo_m_data),
    .m_ready_i(tx_pop)
  );

  // ==========================================================
  // transmit engine
  reg tx_active_q;
  reg [3:0] tx_cnt_q;
  reg [FIFO_WIDTH-1:0] tx_shift_q;
  reg tx_rose_q;
  reg out_q;
  reg rx_active_q;
  wire rx_start;

  // a start seen in this very cycle also blocks the pop, else both engines would claim the link
  assign tx_pop = clk_en_i && fifo_m_valid && running && ~tx_active_q && ~rx_active_q && ~rx_start;

  always @(posedge clock_i) begin
    if (reset_i || (clk_en_i && ~running)) begin
      tx_active_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      tx_shift_q <= {FIFO_WIDTH{1'b0}};
      tx_rose_q <= 1'b0;
      out_q <= `ISL_IDLE_LEVEL;
    end else if (clk_en_i) begin
      if (tx_pop) begin
        tx_active_q <= 1'b1;
        tx_cnt_q <= 4'h0;
        tx_shift_q <= fifo_m_data;
        tx_rose_q <= 1'b0;
        out_q <= `ISL_START_LEVEL;
      end else if (tx_active_q) begin
        if (sclk_rise) begin
          tx_rose_q <= 1'b1;
        end
        // move on only once the far end has sampled the current bit
        if (sclk_fall && tx_rose_q) begin
          tx_rose_q <= 1'b0;
          if (tx_cnt_q == `ISL_TX_LAST_IDX) begin
            tx_active_q <= 1'b0;
            out_q <= `ISL_IDLE_LEVEL;
          end else begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            out_q <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[FIFO_WIDTH-1:1]};
          end
        end
      end
    end
  end

  // ==========================================================
  // receive engine
  reg [3:0] rx_cnt_q;
  reg [7:0] rx_shift_q;
  reg cts_q;
  reg hold_valid_q;
  reg hold_to_b_q;
  reg [7:0] hold_data_q;
  wire rx_done;
  wire target_channel_bit_b;
  wire hold_take;

  // a start is honoured only when clear-to-send was up for it
  assign rx_start = sclk_rise && running && ~rx_active_q && ~tx_active_q
    && (sin_sync_q == `ISL_START_LEVEL) && cts_q;
  assign rx_done = sclk_rise && rx_active_q && (rx_cnt_q == `ISL_RX_TARGET_CHANNEL_BIT_IDX);

  // disabled target channel falls back to the other one
  assign target_channel_bit_b = sin_sync_q ? cfg_b_q : ~cfg_a_q;

  always @(posedge clock_i) begin
    if (reset_i || (clk_en_i && ~running)) begin
      rx_active_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_shift_q <= 8'h00;
    end else if (clk_en_i) begin
      if (rx_start) begin
        rx_active_q <= 1'b1;
        rx_cnt_q <= `ISL_RX_FIRST_DATA_IDX;
      end else if (rx_active_q && sclk_rise) begin
        if (rx_cnt_q == `ISL_RX_TARGET_CHANNEL_BIT_IDX) begin
          rx_active_q <= 1'b0;
        end else begin
          rx_shift_q <= {sin_sync_q, rx_shift_q[7:1]};
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // received byte holding register
  assign hold_take = hold_valid_q &&
    ((hold_to_b_q && rx_b_ready_i) || (~hold_to_b_q && rx_a_ready_i));

  always @(posedge clock_i) begin
    if (reset_i) begin
      hold_valid_q <= 1'b0;
      hold_to_b_q <= 1'b0;
      hold_data_q <= 8'h00;
    end else if (clk_en_i) begin
      if (rx_done) begin
        hold_valid_q <= 1'b1;
        hold_to_b_q <= target_channel_bit_b;
        hold_data_q <= rx_shift_q;
      end else if (hold_take) begin
        hold_valid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // clear to send
  // one holding word means one byte of credit; the far end waits meanwhile
  always @(posedge clock_i) begin
    if (reset_i) begin
      cts_q <= 1'b0;
    end else if (clk_en_i) begin
      if (~running) begin
        cts_q <= 1'b0;
      end else if (rx_active_q) begin
        if (sclk_rise && (rx_cnt_q == `ISL_RX_FIRST_DATA_IDX)) begin
          cts_q <= 1'b0;
        end
      end else if (rx_done || hold_valid_q) begin
        cts_q <= 1'b0;
      end else begin
        cts_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs
  assign rx_data_o = hold_data_q;
  assign rx_a_valid_o = hold_valid_q && ~hold_to_b_q;
  assign rx_b_valid_o = hold_valid_q && hold_to_b_q;
  assign iso_serial_out_o = out_q;
  assign iso_clear_to_send_o = cts_q;

endmodule // isolated_fast_serial_link

// [testbench/link_checker_assertions.sv]
// checker for the isolated serial link, watching the top ports only
// assumes a bind from tb_top and the single clock_i domain
`timescale 1ns/1ps
module link_checker (
  input wire clock_i,
  input wire reset_i,
  input wire mode_cmd_valid_i,
  input wire [7:0] mode_cmd_value_i,
  input wire rx_a_valid_o,
  input wire rx_a_ready_i,
  input wire rx_b_valid_o,
  input wire [7:0] rx_data_o,
  input wire iso_serial_clock_i,
  input wire iso_serial_in_i,
  input wire iso_serial_out_o,
  input wire iso_clear_to_send_o,
  input wire chan_b_pins_fast_o,
  input wire engine_held_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ==========
  // assertions
  chk_hold_cmd: assert property (mode_cmd_valid_i && mode_cmd_value_i == 8'h10 |=> engine_held_o)
    else $error("hold command did not hold the engine");
  chk_release_cmd: assert property (mode_cmd_valid_i && mode_cmd_value_i == 8'h00 |=> !engine_held_o)
    else $error("release command did not free the engine");
  chk_held_quiet: assert property (engine_held_o && $past(engine_held_o) |-> iso_serial_out_o)
    else $error("serial output active while held");
  chk_disabled_idle: assert property (!chan_b_pins_fast_o |-> iso_serial_out_o && !iso_clear_to_send_o)
    else $error("serial function active while disabled");
  chk_pins_fixed: assert property ($stable(chan_b_pins_fast_o))
    else $error("pin routing changed outside reset");
  // sync delay of 2 to 3 cycles plus one serial period of 8 cycles
  chk_cts_drop: assert property ($rose(iso_serial_clock_i) && !iso_serial_in_i && iso_clear_to_send_o
    && iso_serial_out_o && !engine_held_o |-> ##[1:16] !iso_clear_to_send_o)
    else $error("clear to send did not drop after start bit");
  chk_cts_wait: assert property (rx_a_valid_o || rx_b_valid_o |-> !iso_clear_to_send_o)
    else $error("clear to send high with a byte pending");
  chk_rx_stay: assert property (rx_a_valid_o && !rx_a_ready_i |=> rx_a_valid_o && $stable(rx_data_o))
    else $error("received byte lost before taken");
  chk_out_edge: assert property ($changed(iso_serial_out_o) |-> !$past(iso_serial_clock_i, 2))
    else $error("serial output changed outside clock low phase");
endmodule // link_checker

// [testbench/far_end_model.sv]
// far end: makes the serial clock, takes device frames, sends queued frames
// assumes the bench pushes {target_channel_bit, data} into pend; got_tg_o toggles per frame taken
`timescale 1ns/1ps
module far_end_model (
  input wire serial_out_i,
  input wire cts_i,
  input wire stall_i,
  output logic clk_o,
  output logic data_o,
  output logic [9:0] got_o,
  output logic got_tg_o
);
  logic [8:0] pend[$];
  logic [9:0] w;
  initial begin
    clk_o = 1'b0;
    data_o = 1'b1;
    got_o = 10'h000;
    got_tg_o = 1'b0;
    forever begin
      #100;
      if (serial_out_i === 1'b0) begin
        // cannot take the byte yet: clock stands still
        while (stall_i) #100;
        for (int i = 0; i < 10; i++) begin
          #400 clk_o = 1'b1;
          w = {serial_out_i, w[9:1]};
          #400 clk_o = 1'b0;
        end
        got_o = w;
        got_tg_o = !got_tg_o;
        #800;
      end else if (cts_i === 1'b1 && pend.size() > 0) begin
        w = {pend.pop_front(), 1'b0};
        for (int i = 0; i < 10; i++) begin
          data_o = w[i];
          #400 clk_o = 1'b1;
          #400 clk_o = 1'b0;
        end
        data_o = 1'b1;
        #800;
      end
    end
  end
endmodule // far_end_model

// [testbench/tb_top.sv]
// self-checking bench for the isolated serial link
// assumes the far-end model and checker compile first
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0, reset_i = 1'b1, cfg_chan_a_fast_i = 1'b1, cfg_chan_b_fast_i = 1'b1;
  logic mode_cmd_valid_i = 1'b0, tx_a_valid_i = 1'b0, tx_b_valid_i = 1'b0;
  logic rx_a_ready_i = 1'b0, rx_b_ready_i = 1'b0, stall = 1'b0, r = 1'b0;
  logic [7:0] mode_cmd_value_i = 8'h00, tx_a_data_i = 8'h00, tx_b_data_i = 8'h00;
  wire tx_a_ready_o, tx_b_ready_o, rx_a_valid_o, rx_b_valid_o, iso_serial_out_o, iso_clear_to_send_o;
  wire chan_b_pins_fast_o, engine_held_o, iso_serial_clock_i, iso_serial_in_i, got_tg;
  wire [7:0] rx_data_o;
  wire [9:0] got;
  int err_count = 0, comparisons = 0;
  logic [9:0] exp_tx[$];
  logic [8:0] exp_rx[$];
  always #50 clock_i = !clock_i;
  isolated_fast_serial_link dut (.clock_i, .reset_i, .clk_en_i(1'b1), .cfg_chan_a_fast_i, .cfg_chan_b_fast_i,
    .mode_cmd_valid_i, .mode_cmd_value_i, .tx_a_valid_i, .tx_a_data_i, .tx_a_ready_o, .tx_b_valid_i,
    .tx_b_data_i, .tx_b_ready_o, .rx_data_o, .rx_a_valid_o, .rx_a_ready_i, .rx_b_valid_o, .rx_b_ready_i,
    .iso_serial_clock_i, .iso_serial_in_i, .iso_serial_out_o, .iso_clear_to_send_o, .chan_b_pins_fast_o,
    .engine_held_o);
  far_end_model far (.serial_out_i(iso_serial_out_o), .cts_i(iso_clear_to_send_o), .stall_i(stall),
    .clk_o(iso_serial_clock_i), .data_o(iso_serial_in_i), .got_o(got), .got_tg_o(got_tg));
  // ==========
  // tasks
  task check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task do_reset(input logic a, input logic b);
    @(posedge clock_i);
    #1 {cfg_chan_a_fast_i, cfg_chan_b_fast_i, reset_i} = {a, b, 1'b1};
    repeat (8) @(posedge clock_i);
    #1 reset_i = 1'b0;
  endtask
  task push(input logic ch, input logic [7:0] d);
    @(posedge clock_i);
    #1 {tx_b_valid_i, tx_a_valid_i, tx_b_data_i, tx_a_data_i} = {ch, !ch, d, d};
    // ready is combinational: sample it settled before the taking edge
    repeat (2000) begin
      @(negedge clock_i);
      if ((ch ? tx_b_ready_o : tx_a_ready_o) === 1'b1) break;
    end
    @(posedge clock_i);
    #1 {tx_a_valid_i, tx_b_valid_i} = 2'b00;
    exp_tx.push_back({ch, d, 1'b0});
  endtask
  task mode(input logic [7:0] v);
    @(posedge clock_i);
    #1 {mode_cmd_valid_i, mode_cmd_value_i} = {1'b1, v};
    @(posedge clock_i);
    #1 mode_cmd_valid_i = 1'b0;
  endtask
  task rx_frame(input logic target_channel_bit, input logic to_b);
    logic [7:0] d;
    d = 8'($urandom);
    far.pend.push_back({target_channel_bit, d});
    exp_rx.push_back({to_b, d});
  endtask
  task drain;
    repeat (20000) begin
      @(posedge clock_i);
      if (exp_tx.size() == 0 && exp_rx.size() == 0) break;
    end
    check("results left", 10'(exp_tx.size() + exp_rx.size()), 10'h000);
  endtask
  // ==========
  // watchers and stimulus
  always @(posedge clock_i) #1 {rx_a_ready_i, rx_b_ready_i} = 2'($urandom);
  always @(posedge clock_i)
    if ((rx_a_valid_o && rx_a_ready_i) || (rx_b_valid_o && rx_b_ready_i))
      check("received byte", {1'b0, rx_b_valid_o, rx_data_o}, {1'b0, exp_rx.pop_front()});
  always @(got_tg)
    if ($time > 0) check("sent frame", got, exp_tx.pop_front());
  initial begin
    #2000000;
    err_count++;
    end_sim;
  end
  initial begin
    void'($urandom(73432));
    do_reset(1'b1, 1'b1);
    repeat (8) push(1'($urandom), 8'($urandom));
    drain;
    $display("test tx frames done");
    repeat (6) begin
      r = 1'($urandom);
      rx_frame(r, r);
    end
    drain;
    $display("test rx frames done");
    mode(8'h10);
    for (int i = 0; i < 16; i++) push(1'b0, 8'($urandom));
    @(negedge clock_i);
    check("ready when full", {9'h000, tx_a_ready_o}, 10'h000);
    check("held output", {8'h00, engine_held_o, iso_serial_out_o}, 10'h003);
    stall = 1'b1;
    mode(8'h00);
    repeat (200) @(posedge clock_i);
    check("stalled frames", {exp_tx.size() == 16, iso_serial_out_o}, 10'h002);
    stall = 1'b0;
    drain;
    $display("test hold and fill done");
    do_reset(1'b0, 1'b1);
    @(negedge clock_i);
    check("b only ready", {8'h00, chan_b_pins_fast_o, tx_a_ready_o}, 10'h002);
    rx_frame(1'b0, 1'b1);
    rx_frame(1'b1, 1'b1);
    drain;
    $display("test fallback done");
    do_reset(1'b0, 1'b0);
    @(negedge clock_i);
    check("disabled", {7'h00, chan_b_pins_fast_o, iso_clear_to_send_o, iso_serial_out_o}, 10'h001);
    $display("test disabled done");
    end_sim;
  end
endmodule // tb_top
bind isolated_fast_serial_link link_checker chk (.clock_i, .reset_i, .mode_cmd_valid_i, .mode_cmd_value_i,
  .rx_a_valid_o, .rx_a_ready_i, .rx_b_valid_o, .rx_data_o, .iso_serial_clock_i, .iso_serial_in_i,
  .iso_serial_out_o, .iso_clear_to_send_o, .chan_b_pins_fast_o, .engine_held_o);
